// [rtl/size_offset_pkg.sv]
// shared constants and carrier types for the size and antenna offset encoder
package size_offset_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] REG_SIZE_ADDR = 8'h00;
  localparam logic [7:0] REG_OFFSET_ADDR = 8'h04;
  localparam logic [7:0] REG_FIELDS_ADDR = 8'h08;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SIZE_LEN_LSB = 0;
  localparam int SIZE_WID_LSB = 16;
  localparam int SIZE_VALID_BIT = 31;
  localparam int LAT_DM_LSB = 0;
  localparam int LAT_RIGHT_BIT = 8;
  localparam int LAT_VALID_BIT = 9;
  localparam int LNG_DM_LSB = 16;
  localparam int LNG_SENSOR_BIT = 30;
  localparam int LNG_VALID_BIT = 31;
  localparam int FLD_SIZE_LSB = 0;
  localparam int FLD_LAT_LSB = 4;
  localparam int FLD_LNG_LSB = 8;

  // ----------------------------------------
  // dimensions in decimetres
  // ----------------------------------------
  localparam int DIM_W = 12;
  localparam int LAT_W = 7;
  localparam int LNG_W = 10;
  localparam logic [11:0] LEN_LIMIT_DM = 12'h352;
  localparam logic [11:0] WID_LIMIT_DM = 12'h384;
  localparam logic [11:0] LEN_BOUND_DM [0:7] = '{
    12'h096, 12'h0FA, 12'h15E, 12'h1C2, 12'h226, 12'h28A, 12'h2EE, 12'h352};
  localparam logic [11:0] WID_BOUND_DM [1:15] = '{
    12'h0E6, 12'h11D, 12'h154, 12'h14A, 12'h17C, 12'h18B, 12'h1C2, 12'h1C2,
    12'h208, 12'h253, 12'h29E, 12'h2D5, 12'h320, 12'h320, 12'h384};

  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [3:0] SIZE_NO_DATA = 4'h0;
  localparam logic [3:0] SIZE_OVER = 4'hF;
  localparam logic [2:0] LAT_NO_DATA = 3'h0;
  localparam logic [1:0] LAT_MAG_MAX = 2'h3;
  localparam logic [7:0] LAT_STEP_DM = 8'h14;
  localparam logic [7:0] LAT_HALF_DM = 8'h0A;
  localparam logic [4:0] LNG_NO_DATA = 5'h00;
  localparam logic [4:0] LNG_SENSOR = 5'h01;
  localparam logic [4:0] LNG_MIN_CODE = 5'h02;
  localparam logic [4:0] LNG_MAX_CODE = 5'h1F;
  localparam logic [9:0] LNG_LIMIT_DM = 10'h258;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [11:0] length_dm;
    logic [11:0] width_dm;
  } size_cfg_t;

  typedef struct packed {
    logic valid;
    logic right;
    logic [6:0] dist_dm;
  } lat_cfg_t;

  typedef struct packed {
    logic [3:0] size_code;
    logic [2:0] lateral;
    logic [4:0] longitudinal;
  } me_fields_t;

endpackage : size_offset_pkg

// [rtl/lateral_offset_encoder.sv]
// lateral antenna offset to direction and magnitude field
`timescale 1ns/1ps
module lateral_offset_encoder
  import size_offset_pkg::*;
#(
  parameter int OFFSET_W = LAT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // offset in
  input wire lat_cfg_t cfg,
  // field out, bit 2 is direction
  output logic [2:0] field
);

  if (OFFSET_W != LAT_W) begin : g_bad_width
    $error("lateral offset width must match the carrier");
  end

  logic [7:0] rounded;
  logic [1:0] mag;

  // ----------------------------------------
  // round and saturate
  // ----------------------------------------
  // round half step
  assign rounded = 8'((9'(cfg.dist_dm) + 9'(LAT_HALF_DM)) / 9'(LAT_STEP_DM));
  assign mag = (rounded > 8'(LAT_MAG_MAX)) ? LAT_MAG_MAX : rounded[1:0];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      field <= LAT_NO_DATA;
    end else if (!cfg.valid) begin
      field <= LAT_NO_DATA;
    end else if (mag == 2'h0) begin
      // left zero would read as no data, so zero is sent as right
      field <= {1'b1, 2'h0};
    end else begin
      field <= {cfg.right, mag};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_LAT_SAT: assert property (@(posedge clk) disable iff (!rstn)
    cfg.valid && cfg.dist_dm > 7'h3C |=> field[1:0] == 2'h3)
    else $error("lateral offset beyond six metres not saturated");
  AST_LAT_ROUND: assert property (@(posedge clk) disable iff (!rstn)
    cfg.valid && cfg.dist_dm >= 7'h0A && cfg.dist_dm < 7'h1E |=> field[1:0] == 2'h1)
    else $error("lateral offset rounding wrong");
  AST_LAT_NODATA: assert property (@(posedge clk) disable iff (!rstn)
    !cfg.valid |=> field == 3'h0)
    else $error("lateral no data code wrong");
  AST_LAT_DIR: assert property (@(posedge clk) disable iff (!rstn)
    cfg.valid && cfg.dist_dm >= 7'h0A |=> field[2] == $past(cfg.right))
    else $error("lateral direction bit wrong");
  COV_LAT_ZERO: cover property (@(posedge clk) disable iff (!rstn) field == 3'h4);

endmodule : lateral_offset_encoder

// [rtl/aircraft_size_antenna_offset_encoder.sv]
// size code and antenna offset field encoder with register port
//
// What this block does
// - the size code is four bits, a three-bit length category then one width bit.
// - the code is the lowest one whose length and width bounds both cover the aircraft.
// - length above 85 m or width above 90 m gives code 15, and code 0 means no data.
// - length bounds are 15 to 85 m in steps of 10, width bounds follow the fixed table.
// - a lateral offset and a separate longitudinal offset from the nose are provided.
// - the lateral field is a direction bit, 0 left 1 right, then a two-bit magnitude.
// - magnitudes 1 to 3 mean 2, 4, 6 m; zero is no data on the left, zero offset on the right.
// - a lateral offset above 6 m saturates to the 6 m code.
// - the offset is rounded to the nearest 2 m step before coding.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module aircraft_size_antenna_offset_encoder
  import size_offset_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // fields to the message assembler
  output me_fields_t fields
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic fits(input logic [3:0] code, input logic [11:0] len,
                                input logic [11:0] wid);
    fits = (len <= LEN_BOUND_DM[code[3:1]]) && (wid <= WID_BOUND_DM[code]);
  endfunction : fits

  function automatic logic [3:0] size_of(input size_cfg_t c);
    logic [3:0] code;
    code = SIZE_OVER;
    for (int i = 15; i >= 1; i--) begin
      if (fits(4'(i), c.length_dm, c.width_dm)) begin
        code = 4'(i);
      end
    end
    size_of = code;
  endfunction : size_of

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] size_reg;
  logic [31:0] offset_reg;
  size_cfg_t size_cfg;
  lat_cfg_t lat_cfg;
  logic [LNG_W-1:0] lng_dm;
  logic [3:0] next_size;
  logic [4:0] next_lng;
  logic [3:0] size_code;
  logic [4:0] lng_code;
  logic [2:0] lat_field;
  logic [LNG_W-1:0] lng_steps;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      size_reg <= REG_RESET;
    end else if (wr && addr == REG_SIZE_ADDR) begin
      size_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      offset_reg <= REG_RESET;
    end else if (wr && addr == REG_OFFSET_ADDR) begin
      offset_reg <= wdata;
    end
  end

  // one driver per carrier, fields packed in declaration order
  assign size_cfg = {size_reg[SIZE_VALID_BIT], size_reg[SIZE_LEN_LSB +: DIM_W],
                     size_reg[SIZE_WID_LSB +: DIM_W]};
  assign lat_cfg = {offset_reg[LAT_VALID_BIT], offset_reg[LAT_RIGHT_BIT],
                    offset_reg[LAT_DM_LSB +: LAT_W]};
  assign lng_dm = offset_reg[LNG_DM_LSB +: LNG_W];

  // ----------------------------------------
  // size code
  // ----------------------------------------
  // lowest covering code
  always_comb begin
    if (!size_cfg.valid) begin
      next_size = SIZE_NO_DATA;
    end else if (size_cfg.length_dm > LEN_LIMIT_DM || size_cfg.width_dm > WID_LIMIT_DM) begin
      next_size = SIZE_OVER;
    end else begin
      next_size = size_of(size_cfg);
    end
  end

  // ----------------------------------------
  // offsets
  // ----------------------------------------
  // lateral field
  lateral_offset_encoder #(
    .OFFSET_W(LAT_W)
  ) u_lateral (
    .clk(clk),
    .rstn(rstn),
    .cfg(lat_cfg),
    .field(lat_field)
  );

  // longitudinal, rounded, two metres per step
  assign lng_steps = LNG_W'((11'(lng_dm) + 11'(LAT_HALF_DM)) / 11'(LAT_STEP_DM));
  always_comb begin
    if (!offset_reg[LNG_VALID_BIT]) begin
      next_lng = LNG_NO_DATA;
    end else if (offset_reg[LNG_SENSOR_BIT]) begin
      next_lng = LNG_SENSOR;
    end else if (lng_dm > LNG_LIMIT_DM) begin
      next_lng = LNG_MAX_CODE;
    end else if (lng_steps == '0) begin
      // the first code above the sensor flag is the smallest distance
      next_lng = LNG_MIN_CODE;
    end else begin
      next_lng = 5'(lng_steps + 1'b1);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // registered size and longitudinal codes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      size_code <= SIZE_NO_DATA;
      lng_code <= LNG_NO_DATA;
    end else begin
      size_code <= next_size;
      lng_code <= next_lng;
    end
  end

  // lateral field already comes from a flop inside the encoder
  assign fields = {size_code, lat_field, lng_code};

  // unmapped addresses read as zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= REG_RESET;
    end else if (rd) begin
      case (addr)
        REG_SIZE_ADDR: rdata <= size_reg;
        REG_OFFSET_ADDR: rdata <= offset_reg;
        REG_FIELDS_ADDR: begin
          rdata <= '0;
          rdata[FLD_SIZE_LSB +: 4] <= fields.size_code;
          rdata[FLD_LAT_LSB +: 3] <= fields.lateral;
          rdata[FLD_LNG_LSB +: 5] <= fields.longitudinal;
        end
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_SIZE_RESET: assert property (@(posedge clk)
    !rstn |=> fields.size_code == 4'h0 && fields.longitudinal == 5'h00)
    else $error("reset did not force no data codes");
  AST_SIZE_OVER: assert property (@(posedge clk) disable iff (!rstn)
    size_cfg.valid && (size_cfg.length_dm > 12'h352 || size_cfg.width_dm > 12'h384)
    |=> fields.size_code == 4'hF)
    else $error("oversize aircraft not coded 15");
  AST_SIZE_NODATA: assert property (@(posedge clk) disable iff (!rstn)
    !size_cfg.valid |=> fields.size_code == 4'h0)
    else $error("missing dimensions not coded 0");
  AST_SIZE_COVERS: assert property (@(posedge clk) disable iff (!rstn)
    size_cfg.valid && size_cfg.length_dm <= 12'h352 && size_cfg.width_dm <= 12'h384
    |=> fits(fields.size_code, $past(size_cfg.length_dm), $past(size_cfg.width_dm)))
    else $error("size code does not cover the aircraft");
  AST_SIZE_LOWEST: assert property (@(posedge clk) disable iff (!rstn)
    size_cfg.valid ##1 fields.size_code > 4'h1
    |-> !fits(fields.size_code - 4'h1, $past(size_cfg.length_dm), $past(size_cfg.width_dm)))
    else $error("a lower size code would have fitted");
  AST_SIZE_SMALL: assert property (@(posedge clk) disable iff (!rstn)
    size_cfg.valid && size_cfg.length_dm <= 12'h096 && size_cfg.width_dm <= 12'h0E6
    |=> fields.size_code == 4'h1)
    else $error("smallest aircraft not coded 1");
  AST_LNG_SAT: assert property (@(posedge clk) disable iff (!rstn)
    offset_reg[LNG_VALID_BIT] && !offset_reg[LNG_SENSOR_BIT] && lng_dm > 10'h258
    |=> fields.longitudinal == 5'h1F)
    else $error("longitudinal offset not saturated");
  AST_RD_FIELDS: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == REG_FIELDS_ADDR |=> rdata[3:0] == $past(fields.size_code))
    else $error("field readback wrong");
  AST_SIZE_LOWER2: assert property (@(posedge clk) disable iff (!rstn)
    size_cfg.valid ##1 fields.size_code > 4'h2
    |-> !fits(fields.size_code - 4'h2, $past(size_cfg.length_dm), $past(size_cfg.width_dm)))
    else $error("a size code two below would have fitted");
  AST_LNG_NODATA: assert property (@(posedge clk) disable iff (!rstn)
    !offset_reg[LNG_VALID_BIT] |=> fields.longitudinal == 5'h00)
    else $error("longitudinal no data code wrong");
  AST_LNG_SENSOR: assert property (@(posedge clk) disable iff (!rstn)
    offset_reg[LNG_VALID_BIT] && offset_reg[LNG_SENSOR_BIT] |=> fields.longitudinal == 5'h01)
    else $error("longitudinal sensor code wrong");
  AST_LNG_MIN: assert property (@(posedge clk) disable iff (!rstn)
    offset_reg[LNG_VALID_BIT] && !offset_reg[LNG_SENSOR_BIT] && lng_dm < 10'h00A
    |=> fields.longitudinal == 5'h02)
    else $error("smallest longitudinal offset not coded 2");
  AST_RD_SIZE: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == REG_SIZE_ADDR |=> rdata == $past(size_reg))
    else $error("size register readback wrong");
  AST_RD_OFFSET: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == REG_OFFSET_ADDR |=> rdata == $past(offset_reg))
    else $error("offset register readback wrong");
  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr != REG_SIZE_ADDR && addr != REG_OFFSET_ADDR && addr != REG_FIELDS_ADDR
    |=> rdata == 32'h0)
    else $error("unmapped address did not read zero");
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    !rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  COV_SIZE_OVER: cover property (@(posedge clk) disable iff (!rstn) fields.size_code == 4'hF);
  COV_SIZE_MID: cover property (@(posedge clk) disable iff (!rstn) fields.size_code == 4'h9);
  COV_LNG_MAX: cover property (@(posedge clk) disable iff (!rstn) fields.longitudinal == 5'h1F);
  COV_LAT_LEFT: cover property (@(posedge clk) disable iff (!rstn) fields.lateral == 3'h3);

endmodule : aircraft_size_antenna_offset_encoder

// [verif/me_assembler_model.sv]
// message assembler model placing encoded fields at their payload bits
`timescale 1ns/1ps
module me_assembler_model
  import size_offset_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fields from the encoder
  input wire me_fields_t fields,
  // payload bits 21 to 40, gap bits zero
  output logic [21:40] me
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      me <= '0;
    end else begin
      me <= {fields.size_code, 8'h00, fields.lateral, fields.longitudinal};
    end
  end
endmodule : me_assembler_model

// [verif/tb.sv]
// regression bench for the size and antenna offset encoder
`timescale 1ns/1ps
module tb;
  import size_offset_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  me_fields_t fields;
  logic [21:40] me;
  logic [31:0] got;
  int fail_count = 0;
  int samples_checked = 0;
  // ----------------------------------------
  // case tables, dimensions in decimetres
  // ----------------------------------------
  localparam logic [11:0] SZ_L [10] = '{12'h096, 12'h096, 12'h0F0, 12'h0FA, 12'h15E,
    12'h1C2, 12'h352, 12'h353, 12'h064, 12'h352};
  localparam logic [11:0] SZ_W [10] = '{12'h0E6, 12'h0E7, 12'h1F4, 12'h11E, 12'h14F,
    12'h18B, 12'h320, 12'h064, 12'h385, 12'h384};
  localparam logic [3:0] SZ_C [10] = '{4'h1, 4'h2, 4'h9, 4'h3, 4'h5, 4'h6, 4'hE, 4'hF,
    4'hF, 4'hF};
  localparam logic [31:0] OF_IN [8] = '{32'h0000_0000, 32'h8000_0200, 32'hC000_0209,
    32'h8028_020A, 32'h824D_031E, 32'h824E_0231, 32'h8259_0232, 32'h0064_037F};
  localparam logic [2:0] OF_LAT [8] = '{3'h0, 3'h4, 3'h4, 3'h1, 3'h6, 3'h2, 3'h3, 3'h7};
  localparam logic [4:0] OF_LNG [8] = '{5'h00, 5'h02, 5'h01, 5'h03, 5'h1E, 5'h1F, 5'h1F,
    5'h00};

  always #2.5 clk = ~clk;

  aircraft_size_antenna_offset_encoder uut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fields(fields));
  me_assembler_model partner (.clk(clk), .rstn(rstn), .fields(fields), .me(me));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe, taken at its closing edge
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1 check({20'h0, fields}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rd_reg(8'(i * 4), got);
      check(got, REG_RESET);
    end
    $display("test reset done");
    wr_reg(REG_SIZE_ADDR, 32'h0384_0352);
    @(posedge clk);
    rd_reg(REG_FIELDS_ADDR, got);
    check({28'h0, got[3:0]}, {28'h0, SIZE_NO_DATA});
    for (int i = 0; i < 10; i++) begin
      wr_reg(REG_SIZE_ADDR, {1'b1, 3'h0, SZ_W[i], 4'h0, SZ_L[i]});
      @(posedge clk);
      rd_reg(REG_FIELDS_ADDR, got);
      check({28'h0, got[3:0]}, {28'h0, SZ_C[i]});
      check({28'h0, me[21:24]}, {28'h0, SZ_C[i]});
    end
    $display("test size done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(REG_OFFSET_ADDR, OF_IN[i]);
      @(posedge clk);
      rd_reg(REG_FIELDS_ADDR, got);
      check({23'h0, got[12:4]}, {23'h0, OF_LNG[i], 1'b0, OF_LAT[i]});
      check({24'h0, me[33:40]}, {24'h0, OF_LAT[i], OF_LNG[i]});
    end
    $display("test offset done");
    rd_reg(REG_OFFSET_ADDR, got);
    check(got, OF_IN[7]);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    rd_reg(8'h0C, got);
    check(got, 32'h0);
    // fields word is read-only, stray writes ignored
    wr_reg(REG_FIELDS_ADDR, 32'hFFFF_FFFF);
    wr_reg(8'h0C, 32'hFFFF_FFFF);
    @(posedge clk);
    rd_reg(REG_FIELDS_ADDR, got);
    check(got, 32'h0000_007F);
    rd_reg(REG_SIZE_ADDR, got);
    check(got, {1'b1, 3'h0, SZ_W[9], 4'h0, SZ_L[9]});
    rd_reg(REG_OFFSET_ADDR, got);
    check(got, OF_IN[7]);
    $display("test access done");
    @(posedge clk) rstn <= 1'b0;
    @(posedge clk);
    #1 check({20'h0, fields}, 32'h0);
    @(posedge clk) rstn <= 1'b1;
    rd_reg(REG_SIZE_ADDR, got);
    check(got, REG_RESET);
    $display("test mid reset done");
    tally_and_finish();
  end

  // tests need under 1000 cycles, limit is 20000
  initial begin
    #100000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb
